// >>> core/usb_cmd_decoder.sv
// Device-side command decoder: command/data bus, endpoint setup bank, stall,
// validate, clear, status and interrupt readout, IN data through a word FIFO.
// Assumes all inputs synchronous to ref_clk; the USB engine consumes tx words.
`timescale 1ns/1ps
module usb_cmd_decoder
  import usb_cmd_pkg::*;
#(
  parameter int FIFO_DEPTH = FIFO_WORDS
) (
  // clock and reset
  input  wire logic                ref_clk,
  input  wire logic                reset_n,
  input  wire logic                clk_en,
  // host bus
  input  wire logic                cmd_data_select,
  input  wire logic                bus_wr,
  input  wire logic                bus_rd,
  input  wire logic [15:0]         bus_wr_data,
  output logic [15:0]              bus_rd_data,
  output logic                     bus_rd_valid,
  output logic                     bus_wr_ready,
  // USB engine status
  input  wire logic                usb_bus_reset,
  input  wire logic                device_lock,
  input  wire logic [NUM_EP*8-1:0] endpoint_state_reg,
  input  wire logic [NUM_EP*8-1:0] endpoint_error_reg,
  input  wire logic [31:0]         irq_source_reg,
  // IN data towards the engine
  output logic [15:0]              tx_data,
  output logic                     tx_valid,
  input  wire logic                tx_ready,
  output logic [3:0]               tx_ep,
  // OUT data from the engine
  input  wire logic [15:0]         rx_data,
  input  wire logic                rx_avail,
  output logic                     rx_pop,
  // endpoint actions
  output logic [NUM_EP-1:0]        ep_stall,
  output logic                     ep_validate,
  output logic                     ep_clear,
  output logic                     status_taken,
  output logic                     setup_ack,
  output logic [3:0]               cmd_ep,
  output logic                     fifo_alloc_start,
  output logic                     fifo_invalidate,
  output logic                     setup_locked,
  output logic [NUM_EP*8-1:0]      endpoint_setup_flat
);
  initial begin
    if (FIFO_DEPTH < 2) $error("usb_cmd_decoder: fifo depth too small");
  end

  function automatic cmd_kind_type decode_kind(input logic [7:0] code);
    cmd_kind_type k;
    k = KIND_NONE;
    case (code[7:4])
      GRP_WR_BUF:    k = (code == CMD_ILL_WR)  ? KIND_NONE : KIND_WR_BUF;
      GRP_RD_BUF:    k = (code == CMD_ILL_RD)  ? KIND_NONE : KIND_RD_BUF;
      GRP_WR_SETUP:  k = KIND_WR_SETUP;
      GRP_RD_SETUP:  k = KIND_RD_WORD;
      GRP_STALL:     k = KIND_STALL;
      GRP_RD_STATUS: k = KIND_RD_WORD;
      GRP_VALIDATE:  k = (code == CMD_ILL_VAL) ? KIND_NONE : KIND_VALIDATE;
      GRP_CLEAR:     k = (code == CMD_ILL_CLR) ? KIND_NONE : KIND_CLEAR;
      GRP_UNSTALL:   k = KIND_UNSTALL;
      GRP_RD_ERROR:  k = KIND_RD_WORD;
      GRP_RD_COPY:   k = KIND_RD_WORD;
      default: begin
        if (code == CMD_UNLOCK) k = KIND_UNLOCK;
        else if (code == CMD_RD_IRQ) k = KIND_RD_IRQ;
        else if (code == CMD_ACK_SETUP) k = KIND_ACK;
        else k = KIND_NONE;
      end
    endcase
    return k;
  endfunction

  function automatic logic [9:0] word_limit(input logic [7:0] setup);
    return setup[BIT_ISO] ? ISO_MAX_WORDS : CTRL_MAX_WORDS;
  endfunction

  logic [7:0]    setup_reg [NUM_EP];
  cmd_state_type state_reg;
  logic [7:0]    code_reg;
  logic [9:0]    word_cnt_reg;
  logic [9:0]    limit_reg;
  logic [15:0]   irq_hi_reg;
  logic [3:0]    seq_reg;
  logic          cmd_strobe;
  logic          data_wr;
  logic          data_rd;
  logic [7:0]    code_in;
  logic [3:0]    idx_in;
  cmd_kind_type  kind_in;
  logic [7:0]    new_setup;
  logic [7:0]    old_setup;
  logic          fifo_in_valid;
  logic          fifo_in_ready;
  logic          buf_wr_take;
  logic          setup_wr_take;
  logic          status_read;

  assign cmd_strobe    = clk_en && bus_wr && cmd_data_select;
  assign data_wr       = clk_en && bus_wr && !cmd_data_select;
  assign data_rd       = clk_en && bus_rd && !cmd_data_select;
  assign code_in       = bus_wr_data[7:0];
  assign idx_in        = code_in[3:0];
  assign kind_in       = decode_kind(code_in);
  assign buf_wr_take   = data_wr && state_reg == ST_WR_BUF && fifo_in_ready && word_cnt_reg < limit_reg;
  assign fifo_in_valid = data_wr && state_reg == ST_WR_BUF && word_cnt_reg < limit_reg;
  assign setup_wr_take = data_wr && state_reg == ST_WR_SETUP && !setup_locked;
  assign new_setup     = bus_wr_data[7:0];
  assign old_setup     = setup_reg[code_reg[3:0]];
  assign status_read   = data_rd && state_reg == ST_RD_WORD && code_reg[7:4] == GRP_RD_STATUS;

  // command sequencing
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      state_reg    <= ST_IDLE;
      code_reg     <= 8'h00;
      word_cnt_reg <= 10'h000;
      limit_reg    <= 10'h000;
    end else if (clk_en) begin
      if (cmd_strobe) begin
        code_reg     <= code_in;
        word_cnt_reg <= 10'h000;
        limit_reg    <= word_limit(setup_reg[idx_in]);
        case (kind_in)
          KIND_WR_BUF:   state_reg <= ST_WR_BUF;
          KIND_RD_BUF:   state_reg <= ST_RD_BUF;
          KIND_WR_SETUP: state_reg <= ST_WR_SETUP;
          KIND_RD_WORD:  state_reg <= ST_RD_WORD;
          KIND_RD_IRQ:   state_reg <= ST_IRQ_LO;
          KIND_UNLOCK:   state_reg <= ST_UNLOCK;
          default:       state_reg <= ST_IDLE;
        endcase
      end else begin
        case (state_reg)
          ST_WR_BUF: begin
            if (buf_wr_take) word_cnt_reg <= word_cnt_reg + 10'h001;
          end
          ST_RD_BUF: begin
            if (data_rd && word_cnt_reg < limit_reg) word_cnt_reg <= word_cnt_reg + 10'h001;
          end
          ST_WR_SETUP: begin
            if (data_wr) state_reg <= ST_IDLE;
          end
          ST_UNLOCK: begin
            if (data_wr) state_reg <= ST_IDLE;
          end
          ST_RD_WORD: begin
            if (data_rd) state_reg <= ST_IDLE;
          end
          ST_IRQ_LO: begin
            if (data_rd) state_reg <= ST_IRQ_HI;
          end
          ST_IRQ_HI: begin
            if (data_rd) state_reg <= ST_IDLE;
          end
          default: state_reg <= ST_IDLE;
        endcase
      end
    end
  end

  // read answers, registered one cycle after the strobe
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      bus_rd_data  <= 16'h0000;
      bus_rd_valid <= 1'b0;
      irq_hi_reg   <= 16'h0000;
      rx_pop       <= 1'b0;
    end else if (clk_en) begin
      bus_rd_valid <= data_rd;
      rx_pop       <= 1'b0;
      if (data_rd) begin
        case (state_reg)
          ST_RD_BUF: begin
            if (rx_avail && word_cnt_reg < limit_reg) begin
              bus_rd_data <= rx_data;
              rx_pop      <= 1'b1;
            end else begin
              bus_rd_data <= 16'h0000;
            end
          end
          ST_RD_WORD: begin
            case (code_reg[7:4])
              GRP_RD_SETUP:  bus_rd_data <= {8'h00, setup_reg[code_reg[3:0]]};
              GRP_RD_STATUS: bus_rd_data <= {8'h00, endpoint_state_reg[code_reg[3:0]*8 +: 8]};
              GRP_RD_COPY:   bus_rd_data <= {8'h00, endpoint_state_reg[code_reg[3:0]*8 +: 8]};
              GRP_RD_ERROR:  bus_rd_data <= {8'h00, endpoint_error_reg[code_reg[3:0]*8 +: 8]};
              default:       bus_rd_data <= 16'h0000;
            endcase
          end
          ST_IRQ_LO: begin
            bus_rd_data <= irq_source_reg[15:0];
            irq_hi_reg  <= irq_source_reg[31:16];
          end
          ST_IRQ_HI: bus_rd_data <= irq_hi_reg;
          default:   bus_rd_data <= 16'h0000;
        endcase
      end
    end
  end

  // endpoint action pulses
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      ep_validate  <= 1'b0;
      ep_clear     <= 1'b0;
      setup_ack    <= 1'b0;
      status_taken <= 1'b0;
      cmd_ep       <= 4'h0;
    end else if (clk_en) begin
      ep_validate  <= cmd_strobe && kind_in == KIND_VALIDATE;
      ep_clear     <= cmd_strobe && kind_in == KIND_CLEAR;
      setup_ack    <= cmd_strobe && kind_in == KIND_ACK;
      status_taken <= status_read;
      if (cmd_strobe) cmd_ep <= idx_in;
    end
  end

  // stall flags
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      ep_stall <= '0;
    end else if (clk_en && cmd_strobe) begin
      if (kind_in == KIND_STALL) ep_stall[idx_in] <= 1'b1;
      else if (kind_in == KIND_UNSTALL) ep_stall[idx_in] <= 1'b0;
    end
  end

  // register write lock
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      setup_locked <= 1'b0;
    end else if (clk_en) begin
      if (device_lock) setup_locked <= 1'b1;
      else if (data_wr && state_reg == ST_UNLOCK) setup_locked <= 1'b0;
    end
  end

  // endpoint setup bank
  generate
    for (genvar e = 0; e < NUM_EP; e++) begin : g_setup
      always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
          setup_reg[e] <= SETUP_RESET;
        end else if (clk_en) begin
          if (setup_wr_take && code_reg[3:0] == 4'(e)) begin
            setup_reg[e] <= new_setup;
          end
          if (usb_bus_reset) setup_reg[e][BIT_FIFO_EN] <= 1'b0;
        end
      end
      assign endpoint_setup_flat[e*8 +: 8] = setup_reg[e];
    end
  endgenerate

  // allocation sequence and invalidation
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      seq_reg          <= 4'h0;
      fifo_alloc_start <= 1'b0;
      fifo_invalidate  <= 1'b0;
    end else if (clk_en) begin
      fifo_alloc_start <= 1'b0;
      fifo_invalidate  <= 1'b0;
      if (usb_bus_reset) begin
        seq_reg         <= 4'h0;
        fifo_invalidate <= 1'b1;
      end else if (setup_wr_take) begin
        if (old_setup[BIT_FIFO_EN] != new_setup[BIT_FIFO_EN] ||
            old_setup[SIZE_MSB:SIZE_LSB] != new_setup[SIZE_MSB:SIZE_LSB]) begin
          fifo_invalidate <= 1'b1;
        end
        if (code_reg[3:0] == seq_reg) begin
          if (seq_reg == LAST_EP_INDEX) begin
            fifo_alloc_start <= 1'b1;
            seq_reg          <= 4'h0;
          end else begin
            seq_reg <= seq_reg + 4'h1;
          end
        end else begin
          seq_reg <= (code_reg[3:0] == 4'h0) ? 4'h1 : 4'h0;
        end
      end
    end
  end

  // IN endpoint index for the engine
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      tx_ep <= 4'h0;
    end else if (clk_en && cmd_strobe && kind_in == KIND_WR_BUF) begin
      tx_ep <= idx_in;
    end
  end

  word_fifo #(
    .WIDTH (16),
    .DEPTH (FIFO_DEPTH)
  ) u_tx_fifo (
    .ref_clk   (ref_clk),
    .reset_n   (reset_n),
    .clk_en    (clk_en),
    .flush     (fifo_invalidate),
    .in_data   (bus_wr_data),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .out_data  (tx_data),
    .out_valid (tx_valid),
    .out_ready (tx_ready)
  );
  assign bus_wr_ready = fifo_in_ready;

  // checks
  AST_STALL_SET: assert property (@(posedge ref_clk) disable iff (!reset_n)
    cmd_strobe && kind_in == KIND_STALL |=> ep_stall[$past(idx_in)])
    else $error("stall code did not set stall");
  AST_UNSTALL_CLR: assert property (@(posedge ref_clk) disable iff (!reset_n)
    cmd_strobe && kind_in == KIND_UNSTALL |=> !ep_stall[$past(idx_in)])
    else $error("unstall code did not clear stall");
  AST_VALIDATE_ONE: assert property (@(posedge ref_clk) disable iff (!reset_n)
    cmd_strobe |=> ep_validate == ($past(code_in[7:4]) == GRP_VALIDATE && $past(code_in) != CMD_ILL_VAL))
    else $error("validate pulse wrong");
  AST_CLEAR_ONE: assert property (@(posedge ref_clk) disable iff (!reset_n)
    cmd_strobe |=> ep_clear == ($past(code_in[7:4]) == GRP_CLEAR && $past(code_in) != CMD_ILL_CLR))
    else $error("clear pulse wrong");
  AST_ACK_SETUP: assert property (@(posedge ref_clk) disable iff (!reset_n)
    cmd_strobe && code_in == CMD_ACK_SETUP |=> setup_ack ##1 !setup_ack || !clk_en)
    else $error("setup acknowledge not a pulse");
  AST_COPY_NO_CLEAR: assert property (@(posedge ref_clk) disable iff (!reset_n)
    data_rd && state_reg == ST_RD_WORD && code_reg[7:4] == GRP_RD_COPY |=> !status_taken)
    else $error("status copy read cleared status");
  AST_BUS_RESET_DIS: assert property (@(posedge ref_clk) disable iff (!reset_n)
    clk_en && usb_bus_reset |=> !setup_reg[0][BIT_FIFO_EN] && !setup_reg[LAST_EP_INDEX][BIT_FIFO_EN])
    else $error("bus reset left endpoint enabled");
  AST_IRQ_ORDER: assert property (@(posedge ref_clk) disable iff (!reset_n)
    data_rd && state_reg == ST_IRQ_LO |=> bus_rd_valid && bus_rd_data == $past(irq_source_reg[15:0]))
    else $error("interrupt low word wrong");
  AST_WORD_LIMIT: assert property (@(posedge ref_clk) disable iff (!reset_n)
    state_reg == ST_WR_BUF |-> word_cnt_reg <= limit_reg)
    else $error("buffer word count past limit");
  AST_ALLOC_LAST: assert property (@(posedge ref_clk) disable iff (!reset_n)
    fifo_alloc_start |-> $past(code_reg[3:0]) == LAST_EP_INDEX && $past(seq_reg) == LAST_EP_INDEX)
    else $error("allocation started out of sequence");
endmodule // usb_cmd_decoder

// >>> core/usb_cmd_pkg.sv
// Constants for the device-side command decoder: command codes, fields, limits.
// Assumes a 16-bit host bus with a command/data select line and one clock.
// Operation
// - select high means command byte, low data
// - no-data commands run at once; LSW first
// - code 01 loads control IN; 00, 11 illegal
// - codes 02-0F write IN endpoints, size-limited
// - code 10 reads control OUT buffer
// - codes 12-1F read OUT endpoints, size-limited
// - 4x stall, 8x unstall, no data
// - 5x return one endpoint status word
// - 61-6F validate IN buffer; 60 illegal
// - 70, 72-7F clear OUT buffer; 71 illegal
// - Dx returns status copy, clears nothing
// - F4 acknowledges setup on endpoint 0
// - Ax returns error code, upper byte invalid
// - B0 plus one word unlocks register writes
// - C0 returns interrupt source, LSW first
// - N bytes take (N+1)/2 words
// - USB bus reset disables every endpoint
// - allocate after all 16 setups, in order
// - size/enable change invalidates all FIFO contents
// - setup byte: enable, dir, dbl, iso, size
// - direction 0 OUT/read, 1 IN/write
// - 2x write, 3x read endpoint setup
package usb_cmd_pkg;
  localparam int          NUM_EP          = 16;
  localparam logic [7:0]  SETUP_RESET     = 8'h00;
  localparam int          BIT_FIFO_EN     = 7;
  localparam int          BIT_DIR         = 6;
  localparam int          BIT_DBL         = 5;
  localparam int          BIT_ISO         = 4;
  localparam int          SIZE_MSB        = 3;
  localparam int          SIZE_LSB        = 0;
  localparam int          CTRL_MAX_BYTES  = 64;
  localparam int          ISO_MAX_BYTES   = 1023;
  localparam logic [9:0]  CTRL_MAX_WORDS  = 10'((CTRL_MAX_BYTES + 1) / 2);
  localparam logic [9:0]  ISO_MAX_WORDS   = 10'((ISO_MAX_BYTES + 1) / 2);
  localparam logic [3:0]  GRP_WR_BUF      = 4'h0;
  localparam logic [3:0]  GRP_RD_BUF      = 4'h1;
  localparam logic [3:0]  GRP_WR_SETUP    = 4'h2;
  localparam logic [3:0]  GRP_RD_SETUP    = 4'h3;
  localparam logic [3:0]  GRP_STALL       = 4'h4;
  localparam logic [3:0]  GRP_RD_STATUS   = 4'h5;
  localparam logic [3:0]  GRP_VALIDATE    = 4'h6;
  localparam logic [3:0]  GRP_CLEAR       = 4'h7;
  localparam logic [3:0]  GRP_UNSTALL     = 4'h8;
  localparam logic [3:0]  GRP_RD_ERROR    = 4'ha;
  localparam logic [3:0]  GRP_RD_COPY     = 4'hd;
  localparam logic [7:0]  CMD_ILL_WR      = 8'h00;
  localparam logic [7:0]  CMD_ILL_RD      = 8'h11;
  localparam logic [7:0]  CMD_ILL_VAL     = 8'h60;
  localparam logic [7:0]  CMD_ILL_CLR     = 8'h71;
  localparam logic [7:0]  CMD_UNLOCK      = 8'hb0;
  localparam logic [7:0]  CMD_RD_IRQ      = 8'hc0;
  localparam logic [7:0]  CMD_ACK_SETUP   = 8'hf4;
  localparam logic [3:0]  LAST_EP_INDEX   = 4'hf;
  localparam int          FIFO_WORDS      = 32;

  typedef enum logic [3:0] {
    KIND_NONE     = 4'h0,
    KIND_WR_BUF   = 4'h1,
    KIND_RD_BUF   = 4'h2,
    KIND_WR_SETUP = 4'h3,
    KIND_RD_WORD  = 4'h4,
    KIND_STALL    = 4'h5,
    KIND_UNSTALL  = 4'h6,
    KIND_VALIDATE = 4'h7,
    KIND_CLEAR    = 4'h8,
    KIND_ACK      = 4'h9,
    KIND_UNLOCK   = 4'ha,
    KIND_RD_IRQ   = 4'hb
  } cmd_kind_type;

  typedef enum logic [2:0] {
    ST_IDLE     = 3'h0,
    ST_WR_BUF   = 3'h1,
    ST_RD_BUF   = 3'h2,
    ST_WR_SETUP = 3'h3,
    ST_RD_WORD  = 3'h4,
    ST_IRQ_LO   = 3'h5,
    ST_IRQ_HI   = 3'h6,
    ST_UNLOCK   = 3'h7
  } cmd_state_type;
endpackage

// >>> core/word_fifo.sv
// Word FIFO with a registered output stage and registered full flag.
// Assumes one clock, synchronous active-low reset and a freezing clock enable.
`timescale 1ns/1ps
module word_fifo
  import usb_cmd_pkg::*;
#(
  parameter int WIDTH = 16,
  parameter int DEPTH = FIFO_WORDS
) (
  // clock
  input  wire logic             ref_clk,
  input  wire logic             reset_n,
  input  wire logic             clk_en,
  input  wire logic             flush,
  // fill side
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  // drain side
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) $error("word_fifo: depth must be a power of two");
  end

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic [AW:0]      count_next;
  logic             push;
  logic             pop;

  assign push       = in_valid && in_ready;
  assign pop        = (count_reg != '0) && (!out_valid || out_ready);
  assign count_next = count_reg + (AW+1)'(push) - (AW+1)'(pop);

  always_ff @(posedge ref_clk) begin
    if (clk_en && push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n || (clk_en && flush)) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
      in_ready   <= 1'b1;
    end else if (clk_en) begin
      wr_ptr_reg <= wr_ptr_reg + AW'(push);
      rd_ptr_reg <= rd_ptr_reg + AW'(pop);
      count_reg  <= count_next;
      // output stage holds one word, so total stays at DEPTH
      in_ready   <= count_next < (AW+1)'(DEPTH - 1);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n || (clk_en && flush)) begin
      out_valid <= 1'b0;
      out_data  <= '0;
    end else if (clk_en) begin
      if (pop) begin
        out_valid <= 1'b1;
        out_data  <= mem_reg[rd_ptr_reg];
      end else if (out_ready) begin
        out_valid <= 1'b0;
      end
    end
  end
endmodule // word_fifo

// >>> bench/usb_engine_model.sv
// USB engine stand-in: drains IN words from the decoder, supplies OUT words.
// Assumes the decoder's tx/rx handshakes on ref_clk; hold stalls both sides.
`timescale 1ns/1ps
module usb_engine_model (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  // stall control from the bench
  input  wire logic        hold,
  // IN words
  input  wire logic [15:0] tx_data,
  input  wire logic        tx_valid,
  output logic             tx_ready,
  // OUT words
  output logic [15:0]      rx_data,
  output logic             rx_avail,
  input  wire logic        rx_pop
);
  int          got;
  logic [15:0] last;
  logic [7:0]  rx_idx;
  assign tx_ready = !hold;
  assign rx_avail = !hold;
  // no word present: show inverted data, never a stale copy
  assign rx_data  = rx_avail ? {8'h5a, rx_idx} : ~{8'h5a, rx_idx};
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      got    <= 0;
      rx_idx <= 8'h00;
    end else begin
      if (tx_valid && tx_ready) begin
        got  <= got + 1;
        last <= tx_data;
      end
      if (rx_pop) begin
        rx_idx <= rx_idx + 8'h01;
      end
    end
  end
endmodule // usb_engine_model

// >>> bench/tb_usb_cmd_decoder.sv
// Self-checking bench for the command decoder: host bus tasks and scenarios.
// Assumes usb_engine_model on the engine side and a 250 MHz clock.
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin errors++; $display("unexpected t=%0t got %h exp %h", $time, a, b); end end
module tb_usb_cmd_decoder
  import usb_cmd_pkg::*;
;
  logic         ref_clk = 0, reset_n = 0, sel = 0, wr = 0, rd = 0, lock = 0, bres = 0, hold = 0;
  logic [15:0]  wdata = 16'h0000, rdata, txd, rxd, stall, r;
  logic         rvalid, wready, txv, txr, rxa, pop, val, clr, taken, ack, alloc, inval, locked;
  logic [127:0] st, er, setup_flat;
  logic [31:0]  irq = 32'h8765_4321;
  logic [3:0]   txep, cep;
  int           errors = 0, tests_run = 0, cyc = 0, n_take = 0, n_alloc = 0, n_inv = 0, n_pop = 0;

  usb_cmd_decoder dut (.ref_clk(ref_clk), .reset_n(reset_n), .clk_en(1'b1), .cmd_data_select(sel),
    .bus_wr(wr), .bus_rd(rd), .bus_wr_data(wdata), .bus_rd_data(rdata), .bus_rd_valid(rvalid),
    .bus_wr_ready(wready), .usb_bus_reset(bres), .device_lock(lock), .endpoint_state_reg(st),
    .endpoint_error_reg(er), .irq_source_reg(irq), .tx_data(txd), .tx_valid(txv), .tx_ready(txr),
    .tx_ep(txep), .rx_data(rxd), .rx_avail(rxa), .rx_pop(pop), .ep_stall(stall), .ep_validate(val),
    .ep_clear(clr), .status_taken(taken), .setup_ack(ack), .cmd_ep(cep), .fifo_alloc_start(alloc),
    .fifo_invalidate(inval), .setup_locked(locked), .endpoint_setup_flat(setup_flat));
  usb_engine_model eng (.ref_clk(ref_clk), .reset_n(reset_n), .hold(hold), .tx_data(txd),
    .tx_valid(txv), .tx_ready(txr), .rx_data(rxd), .rx_avail(rxa), .rx_pop(pop));

  initial begin
    forever #2 ref_clk = ~ref_clk;
  end

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // pulse counters and hang guard
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    n_take <= n_take + int'(taken);
    n_alloc <= n_alloc + int'(alloc);
    n_inv <= n_inv + int'(inval);
    n_pop <= n_pop + int'(pop);
    if (cyc == 6000) begin
      errors++;
      give_verdict();
    end
  end

  task automatic put(input logic s, input logic [15:0] d);
    @(posedge ref_clk) #1;
    sel = s;
    wr = 1;
    wdata = d;
    @(posedge ref_clk) #1;
    wr = 0;
  endtask
  task automatic cmd(input logic [7:0] c);
    put(1'b1, {8'h00, c});
  endtask
  task automatic rdw(output logic [15:0] d);
    @(posedge ref_clk) #1;
    sel = 0;
    rd = 1;
    @(posedge ref_clk) #1;
    rd = 0;
    `CHK(rvalid, 1'b1)
    d = rdata;
  endtask
  task automatic rd1(input logic [7:0] c, input logic [15:0] e);
    cmd(c);
    rdw(r);
    `CHK(r, e)
  endtask
  task automatic drain;
    for (int k = 0; k < 200 && txv !== 1'b0; k++) @(posedge ref_clk);
    repeat (4) @(posedge ref_clk);
    #1;
  endtask
  task automatic done(input string n);
    $display("test %s done", n);
  endtask
  function automatic logic [7:0] sv(input int i);
    return 8'h80 | (i[0] ? 8'h40 : 8'h00) | 8'(i);
  endfunction

  initial begin
    for (int i = 0; i < 16; i++) begin
      st[8*i+:8] = 8'h10 + 8'(i);
      er[8*i+:8] = 8'h40 + 8'(i);
    end
    repeat (6) @(posedge ref_clk);
    #1 reset_n = 1;
    `CHK(setup_flat, 128'h0)
    for (int i = 0; i < 16; i++) rd1(8'h30 | 8'(i), 16'h0000);
    done("reset");
    for (int i = 0; i < 16; i++) begin
      cmd(8'h40 | 8'(i));
      `CHK(stall, 16'h0001 << i)
      `CHK(cep, 4'(i))
      cmd(8'h80 | 8'(i));
      `CHK(stall, 16'h0000)
    end
    done("stall");
    for (int i = 0; i < 16; i++) begin
      rd1(8'h50 | 8'(i), {8'h00, st[8*i+:8]});
      rd1(8'hd0 | 8'(i), {8'h00, st[8*i+:8]});
      rd1(8'ha0 | 8'(i), {8'h00, er[8*i+:8]});
    end
    `CHK(n_take, 16)
    cmd(CMD_RD_IRQ);
    rdw(r);
    `CHK(r, irq[15:0])
    rdw(r);
    `CHK(r, irq[31:16])
    done("status");
    for (int i = 0; i < 16; i++) begin
      cmd(8'h20 | 8'(i));
      put(1'b0, {8'h00, sv(i)});
    end
    for (int i = 0; i < 16; i++) rd1(8'h30 | 8'(i), {8'h00, sv(i)});
    `CHK(n_alloc, 1)
    `CHK(n_inv, 16)
    done("setup");
    hold = 1;
    cmd(8'h03);
    for (int k = 0; k < 33; k++) put(1'b0, 16'h0a00 + 16'(k));
    `CHK(wready, 1'b0)
    `CHK(txep, 4'h3)
    hold = 0;
    drain();
    `CHK(eng.got, 32)
    `CHK(eng.last, 16'h0a1f)
    `CHK(wready, 1'b1)
    cmd(8'h63);
    `CHK(val, 1'b1)
    cmd(CMD_ILL_VAL);
    `CHK(val, 1'b0)
    cmd(CMD_ILL_WR);
    put(1'b0, 16'h1234);
    cmd(8'h01);
    put(1'b0, 16'h0b0b);
    drain();
    `CHK(eng.got, 33)
    `CHK(eng.last, 16'h0b0b)
    done("in_buffer");
    hold = 1;
    cmd(8'h12);
    rdw(r);
    `CHK(r, 16'h0000)
    hold = 0;
    for (int k = 0; k < 4; k++) begin
      rdw(r);
      `CHK(r, 16'h5a00 + 16'(k))
    end
    cmd(8'h72);
    `CHK(clr, 1'b1)
    `CHK(n_pop, 4)
    cmd(CMD_ILL_CLR);
    `CHK(clr, 1'b0)
    cmd(8'h70);
    `CHK(clr, 1'b1)
    cmd(CMD_ACK_SETUP);
    `CHK(ack, 1'b1)
    rd1(CMD_ILL_RD, 16'h0000);
    rd1(8'h10, 16'h5a04);
    done("out_buffer");
    @(posedge ref_clk) #1 lock = 1;
    @(posedge ref_clk) #1 lock = 0;
    `CHK(locked, 1'b1)
    cmd(8'h25);
    put(1'b0, 16'h0000);
    rd1(8'h35, {8'h00, sv(5)});
    cmd(CMD_UNLOCK);
    put(1'b0, 16'h0000);
    `CHK(locked, 1'b0)
    cmd(8'h25);
    put(1'b0, 16'h0055);
    rd1(8'h35, 16'h0055);
    @(posedge ref_clk) #1 bres = 1;
    @(posedge ref_clk) #1 bres = 0;
    for (int i = 0; i < 16; i++) rd1(8'h30 | 8'(i), {8'h00, (i == 5 ? 8'h55 : sv(i)) & 8'h7f});
    done("lock_and_bus_reset");
    // iso endpoint passes more than the 32-word bulk limit
    cmd(8'h24);
    put(1'b0, 16'h00d4);
    cmd(8'h04);
    for (int k = 0; k < 40; k++) put(1'b0, 16'h0c00 + 16'(k));
    drain();
    `CHK(eng.got, 73)
    `CHK(eng.last, 16'h0c27)
    done("iso");
    give_verdict();
  end
endmodule // tb_usb_cmd_decoder
